//--- design/pickup_decode_speed_guard.sv
// Pickup event decoder, speed measurement and ignition speed guard.
// Assumes pickup levels already conditioned to logic and synchronous to pclk.
//
// Behaviour
// - Extra-tooth disc: N even events step position, extra marks index.
// - Missing-tooth disc: gap of one absent event marks the index.
// - Single-event disc: one pulse per shaft turn.
// - For extra and missing discs the event setting is nominal N.
// - Event count accepted only from 3 to 500 when several expected.
// - Summed event rate at overspeed over 8 kHz is refused.
// - Each input marked camshaft or crankshaft and scaled to engine speed.
// - Passive, active idle-high and active idle-low pickup modes.
// - Firing inhibited below release speed; release at most nominal/7.
// - Security speed at most half the nominal speed.
// - Below security speed on and off requests act immediately.
// - Switched off above security speed: locked until standstill.
// - Reaching overspeed shuts ignition off.
// - Overspeed above 6000 rpm or over 8 kHz events is refused.
// - Overspeed giving over 250 Hz firing per board is refused.
// - Evenly spaced disc gives N uniform events per turn.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module pickup_decode_speed_guard #(
  parameter int unsigned STOP_CYCLES = pickup_pkg::STOP_CYC
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [1:0]       pu_level,
  output pickup_pkg::ign_out_t  ign,
  output logic      [1:0]       index_pulse
);
  import pickup_pkg::*;

  localparam logic [23:0] STOP_LIM = 24'(STOP_CYCLES - 1);

  typedef struct packed {
    in_cfg_t [1:0]    sh_cfg;
    in_cfg_t [1:0]    cfg;
    spd_cfg_t         sh_spd;
    spd_cfg_t         spd;
    logic [7:0]       sh_load;
    logic [7:0]       load;
    logic             req;
    logic             cfg_ok;
    logic [3:0]       err;
    logic [1:0]       lvl_prev;
    logic [1:0][23:0] cnt;
    logic [1:0][23:0] per;
    logic [1:0][8:0]  seen;
    logic [1:0]       armed;
    logic [1:0]       skip;
    logic [1:0]       idx;
    logic             stopped;
    logic             div_busy;
    logic [4:0]       div_n;
    logic [33:0]      div_rem;
    logic [30:0]      div_num;
    logic [32:0]      div_den;
    logic [30:0]      div_quo;
    logic [15:0]      rpm;
    ign_st_t          st;
    ign_out_t         ign;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } state_t;

  state_t q, d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Edge that counts as an event for the chosen pickup mode
  function automatic logic edge_hit(pu_mode_t m, logic prev, logic cur);
    if (m == PU_IDLE_HIGH) edge_hit = prev & ~cur;
    else edge_hit = ~prev & cur;
  endfunction : edge_hit

  // Nominal spacing count per turn; single disc has one
  function automatic logic [8:0] spacing(in_cfg_t c);
    spacing = (c.disc == DISC_SINGLE) ? 9'h001 : c.events;
  endfunction : spacing

  // Weighted events per two crank turns, for the rate limit
  function automatic logic [15:0] rate_wt(in_cfg_t c);
    logic [9:0] tot;
    tot = {1'b0, spacing(c)};
    if (c.disc == DISC_EXTRA) tot = tot + 10'h001;
    if (c.disc == DISC_MISSING) tot = tot - 10'h001;
    if (c.disc == DISC_UNUSED) tot = 10'h000;
    rate_wt = c.cam ? {6'h00, tot} : {5'h00, tot, 1'b0};
  endfunction : rate_wt

  function automatic logic ev_bad(in_cfg_t c);
    ev_bad = (c.disc == DISC_EVEN || c.disc == DISC_EXTRA ||
              c.disc == DISC_MISSING) &&
             (c.events < EV_MIN || c.events > EV_MAX);
  endfunction : ev_bad

  logic acc_done;
  logic commit;
  assign acc_done = psel & penable & q.pready;
  assign commit   = acc_done & pwrite & (paddr == OFF_CTRL) &
                    pwdata[CTRL_COMMIT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // One process computes every next value from the current state
  always_comb begin
    logic        ev;
    logic [23:0] p;
    logic        upd0;
    logic [33:0] rsh;
    logic [31:0] rate;
    logic [31:0] brd;
    logic [3:0]  err;
    logic        mapped;
    ev     = 1'b0;
    p      = 24'h000000;
    upd0   = 1'b0;
    rsh    = 34'h000000000;
    rate   = 32'h00000000;
    brd    = 32'h00000000;
    err    = 4'h0;
    mapped = 1'b0;
    d      = q;
    d.idx  = 2'b00;

    // Pickup decoding, one pass per input
    for (int i = 0; i < 2; i++) begin
      ev = edge_hit(q.cfg[i].mode, q.lvl_prev[i], pu_level[i]) &&
           q.cfg[i].disc != DISC_UNUSED;
      p  = q.cnt[i];
      d.lvl_prev[i] = pu_level[i];
      // Saturating, so a stopped shaft cannot wrap into a short period
      if (q.cnt[i] != 24'hFFFFFF) d.cnt[i] = q.cnt[i] + 24'h000001;
      if (ev) begin
        d.cnt[i] = 24'h000001; // Count then equals the interval
        if (q.seen[i] != spacing(q.cfg[i])) d.seen[i] = q.seen[i] + 9'h001;
        else d.armed[i] = 1'b1;
        case (q.cfg[i].disc)
          DISC_SINGLE: begin
            d.per[i] = p;
            d.idx[i] = 1'b1;
          end
          DISC_MISSING: begin
            // Interval over one and a half teeth is the gap
            if (q.armed[i] && ({1'b0, p} > {1'b0, q.per[i]} +
                {2'b00, q.per[i][23:1]})) begin
              d.idx[i] = 1'b1;
            end else begin
              d.per[i] = p;
            end
          end
          DISC_EXTRA: begin
            // Both halves of the split interval are kept out of speed
            if (q.skip[i]) begin
              d.skip[i] = 1'b0;
            end else if (q.armed[i] && p < q.per[i] -
                         {2'b00, q.per[i][23:2]}) begin
              d.idx[i]  = 1'b1;
              d.skip[i] = 1'b1;
            end else begin
              d.per[i] = p;
            end
          end
          default: d.per[i] = p;
        endcase
        if (i == 0) upd0 = !q.skip[i] && !d.skip[i] && !d.idx[i] ||
            q.cfg[i].disc == DISC_SINGLE;
      end
    end

    // Standstill watch on the speed input
    if (ev_hit0()) d.stopped = 1'b0;
    else if (q.cnt[0] >= STOP_LIM) d.stopped = 1'b1;

    // Serial divider: turn length in cycles to rpm, 31 steps
    if (q.div_busy) begin
      rsh = {q.div_rem[32:0], q.div_num[30]};
      d.div_num = {q.div_num[29:0], 1'b0};
      if (rsh >= {1'b0, q.div_den}) begin
        d.div_rem = rsh - {1'b0, q.div_den};
        d.div_quo = {q.div_quo[29:0], 1'b1};
      end else begin
        d.div_rem = rsh;
        d.div_quo = {q.div_quo[29:0], 1'b0};
      end
      d.div_n = q.div_n - 5'h01;
      if (q.div_n == 5'h00) begin
        d.div_busy = 1'b0;
        d.rpm = (d.div_quo[30:16] != 15'h0000) ? 16'hFFFF : d.div_quo[15:0];
      end
    end else if (upd0 && !q.stopped && d.per[0] != 24'h000000) begin
      // Period times spacing count gives cycles per shaft turn; the interval
      // that ends a standstill is no period and would fake a low speed
      d.div_busy = 1'b1;
      d.div_n    = 5'h1E;
      d.div_rem  = 34'h000000000;
      d.div_quo  = 31'h00000000;
      d.div_den  = 33'(d.per[0]) * 33'(spacing(q.cfg[0]));
      d.div_num  = q.cfg[0].cam ? CAM_NUM : CRANK_NUM;
    end
    if (d.stopped) d.rpm = 16'h0000;

    // Configuration check on commit; a refused set leaves the old one
    rate = 32'(q.sh_spd.ovs) * 32'(rate_wt(q.sh_cfg[0]) +
                                  rate_wt(q.sh_cfg[1]));
    brd  = 32'(q.sh_spd.ovs) * 32'(q.sh_load);
    err[ERR_EVENTS] = ev_bad(q.sh_cfg[0]) | ev_bad(q.sh_cfg[1]);
    err[ERR_RATE]   = rate > RATE_SUM_MAX;
    err[ERR_SPEEDS] = 20'(q.sh_spd.rel) * 20'(REL_DIV) > 20'(q.sh_spd.nom) ||
                      20'(q.sh_spd.sec) * 20'(SEC_DIV) >
                      20'(q.sh_spd.nom);
    err[ERR_OVS]    = q.sh_spd.ovs > OVS_MAX ||
                      brd > BOARD_MAX;
    if (commit) begin
      d.err = err;
      if (err == 4'h0) begin
        d.cfg    = q.sh_cfg;
        d.spd    = q.sh_spd;
        d.load   = q.sh_load;
        d.cfg_ok = 1'b1;
        d.armed  = 2'b00;
        d.seen   = '0;
        d.skip   = 2'b00;
      end
    end

    // Ignition guard
    case (q.st)
      IGN_OFF: begin
        if (q.req && q.cfg_ok) d.st = IGN_ON;
      end
      IGN_ON: begin
        if (q.rpm >= q.spd.ovs) begin
          d.st = IGN_LOCK;
          d.ign.overspeed = 1'b1;
        end else if (!q.req) begin
          d.st = (q.rpm > q.spd.sec) ? IGN_LOCK : IGN_OFF;
        end
      end
      IGN_LOCK: begin
        if (q.stopped) begin
          d.st = IGN_OFF;
          d.ign.overspeed = 1'b0;
        end
      end
      default: d.st = IGN_OFF;
    endcase
    d.ign.locked  = d.st == IGN_LOCK;
    d.ign.fire_en = d.st == IGN_ON && d.rpm >= d.spd.rel &&
                    !d.stopped;

    // APB: one wait state, writes land on the completing edge
    d.pready  = psel & penable & ~q.pready;
    d.pslverr = 1'b0;
    d.prdata  = 32'h00000000;
    if (acc_done && pwrite) begin
      case (paddr)
        OFF_CTRL: d.req        = pwdata[CTRL_REQ_BIT];
        OFF_IN0:  d.sh_cfg[0]  = in_cfg_t'(pwdata[14:0]);
        OFF_IN1:  d.sh_cfg[1]  = in_cfg_t'(pwdata[14:0]);
        OFF_REL:  d.sh_spd.rel = pwdata[15:0];
        OFF_SEC:  d.sh_spd.sec = pwdata[15:0];
        OFF_NOM:  d.sh_spd.nom = pwdata[15:0];
        OFF_OVS:  d.sh_spd.ovs = pwdata[15:0];
        OFF_LOAD: d.sh_load    = pwdata[7:0];
        default:  d.sh_load    = q.sh_load;
      endcase
    end
    if (d.pready) begin
      mapped = 1'b1;
      case (paddr)
        OFF_CTRL:   d.prdata = {31'h00000000, q.req};
        OFF_STATUS: d.prdata = {20'h00000, q.armed, q.ign.overspeed,
                                q.stopped, q.cfg_ok, q.st, q.err, 1'b0};
        OFF_IN0:    d.prdata = {17'h00000, q.sh_cfg[0]};
        OFF_IN1:    d.prdata = {17'h00000, q.sh_cfg[1]};
        OFF_REL:    d.prdata = {16'h0000, q.sh_spd.rel};
        OFF_SEC:    d.prdata = {16'h0000, q.sh_spd.sec};
        OFF_NOM:    d.prdata = {16'h0000, q.sh_spd.nom};
        OFF_OVS:    d.prdata = {16'h0000, q.sh_spd.ovs};
        OFF_LOAD:   d.prdata = {24'h000000, q.sh_load};
        OFF_RPM:    d.prdata = {16'h0000, q.rpm};
        default:    mapped = 1'b0;
      endcase
      d.pslverr = ~mapped;
    end
  end

  // Event on the speed input, used only by the standstill watch
  function automatic logic ev_hit0();
    ev_hit0 = edge_hit(q.cfg[0].mode, q.lvl_prev[0], pu_level[0]) &&
              q.cfg[0].disc != DISC_UNUSED;
  endfunction : ev_hit0

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.sh_cfg   <= {IN_CFG_RST, IN_CFG_RST};
      q.cfg      <= {IN_CFG_RST, IN_CFG_RST};
      q.sh_spd   <= SPD_RST;
      q.spd      <= SPD_RST;
      q.sh_load  <= LOAD_RST;
      q.load     <= LOAD_RST;
      q.stopped  <= 1'b1; // No speed is known until events arrive
      q.st       <= IGN_OFF;
    end else begin
      q <= d;
    end
  end

  assign prdata      = q.prdata;
  assign pready      = q.pready;
  assign pslverr     = q.pslverr;
  assign ign         = q.ign;
  assign index_pulse = q.idx;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_fire_release;
    q.ign.fire_en |-> q.rpm >= q.spd.rel && q.st == IGN_ON;
  endproperty
  a_fire_release: assert property (p_fire_release)
    else $error("firing enabled below release speed");

  property p_ovs_shut;
    q.st == IGN_ON && q.rpm >= q.spd.ovs |=> q.st == IGN_LOCK
      && !q.ign.fire_en && q.ign.overspeed;
  endproperty
  a_ovs_shut: assert property (p_ovs_shut)
    else $error("overspeed did not shut ignition off");

  property p_lock_hold;
    q.st == IGN_LOCK && !q.stopped |=> q.st == IGN_LOCK;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("lockout left before standstill");

  property p_off_high;
    q.st == IGN_ON && !q.req && q.rpm > q.spd.sec && q.rpm < q.spd.ovs
      |=> q.st == IGN_LOCK ##1 !q.ign.fire_en;
  endproperty
  a_off_high: assert property (p_off_high)
    else $error("switch-off above security speed not locked");

  property p_off_low;
    q.st == IGN_ON && !q.req && q.rpm <= q.spd.sec && q.rpm < q.spd.ovs
      |=> q.st == IGN_OFF;
  endproperty
  a_off_low: assert property (p_off_low)
    else $error("switch-off below security speed not immediate");

  property p_on_low;
    q.st == IGN_OFF && q.req && q.cfg_ok |=> q.st == IGN_ON;
  endproperty
  a_on_low: assert property (p_on_low)
    else $error("switch-on request not honoured");

  property p_ovs_refuse;
    commit && q.sh_spd.ovs > OVS_MAX |=> q.err[ERR_OVS] && $stable(q.spd);
  endproperty
  a_ovs_refuse: assert property (p_ovs_refuse)
    else $error("overspeed above limit accepted");

  property p_events_range;
    commit && ev_bad(q.sh_cfg[0]) |=> q.err[ERR_EVENTS] && $stable(q.cfg);
  endproperty
  a_events_range: assert property (p_events_range)
    else $error("event count outside range accepted");

  property p_index_armed;
    index_pulse[0] && q.cfg[0].disc != DISC_SINGLE |-> $past(q.armed[0]);
  endproperty
  a_index_armed: assert property (p_index_armed)
    else $error("index reported before one full turn");

  property p_stop_zero;
    q.stopped |-> q.rpm == 16'h0000 && !q.ign.fire_en;
  endproperty
  a_stop_zero: assert property (p_stop_zero)
    else $error("speed shown while stopped");

  property p_apb_one;
    q.pready |=> !q.pready;
  endproperty
  a_apb_one: assert property (p_apb_one)
    else $error("ready held longer than one cycle");

  c_fire:   cover property (!q.ign.fire_en ##1 q.ign.fire_en);
  c_lock:   cover property (q.st == IGN_ON ##1 q.st == IGN_LOCK);
  c_index:  cover property (index_pulse[0]);
  c_commit: cover property (commit ##1 q.cfg_ok && q.err == 4'h0);

endmodule : pickup_decode_speed_guard

//--- design/pickup_pkg.sv
// Constants, types and register map of the pickup decoder and speed guard.
// Assumes a 10 MHz APB clock and digital, already conditioned pickup levels.
package pickup_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned STOP_TIME_MS = 1000;     // No event this long: stop
  localparam int unsigned STOP_CYC     = (CLK_HZ / 1000) * STOP_TIME_MS;
  localparam logic [30:0] CRANK_NUM    = 31'(CLK_HZ * 60);  // Cycles per min
  localparam logic [30:0] CAM_NUM      = 31'(CLK_HZ * 120); // Cam turns half

  // Configuration limits
  localparam logic [8:0]  EV_MIN       = 9'h003;
  localparam logic [8:0]  EV_MAX       = 9'h1F4;   // 500
  localparam logic [15:0] OVS_MAX      = 16'h1770; // 6000 rpm
  localparam int unsigned EVT_RATE_HZ  = 8000;
  localparam int unsigned IGN_RATE_HZ  = 250;
  localparam logic [31:0] RATE_SUM_MAX = 32'(EVT_RATE_HZ * 120);
  localparam logic [31:0] BOARD_MAX    = 32'(IGN_RATE_HZ * 120);
  localparam logic [3:0]  REL_DIV      = 4'h7;
  localparam logic [3:0]  SEC_DIV      = 4'h2;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IN0    = 8'h08;
  localparam logic [7:0] OFF_IN1    = 8'h0C;
  localparam logic [7:0] OFF_REL    = 8'h10;
  localparam logic [7:0] OFF_SEC    = 8'h14;
  localparam logic [7:0] OFF_NOM    = 8'h18;
  localparam logic [7:0] OFF_OVS    = 8'h1C;
  localparam logic [7:0] OFF_LOAD   = 8'h20;
  localparam logic [7:0] OFF_RPM    = 8'h24;

  // Field positions
  localparam int unsigned CTRL_REQ_BIT    = 0;
  localparam int unsigned CTRL_COMMIT_BIT = 1;
  localparam int unsigned ERR_EVENTS      = 0;
  localparam int unsigned ERR_RATE        = 1;
  localparam int unsigned ERR_SPEEDS      = 2;
  localparam int unsigned ERR_OVS         = 3;

  typedef enum logic [2:0] {
    DISC_UNUSED, DISC_EVEN, DISC_EXTRA, DISC_MISSING, DISC_SINGLE
  } disc_t;

  typedef enum logic [1:0] {PU_PASSIVE, PU_IDLE_HIGH, PU_IDLE_LOW} pu_mode_t;

  // Pickup input setting, register bits 14:0
  typedef struct packed {
    logic     cam;     // 14: events come from the camshaft
    pu_mode_t mode;    // 13:12
    logic [8:0] events; // 11:3 nominal N
    disc_t    disc;    // 2:0
  } in_cfg_t;

  typedef struct packed {
    logic [15:0] rel;
    logic [15:0] sec;
    logic [15:0] nom;
    logic [15:0] ovs;
  } spd_cfg_t;

  typedef struct packed {
    logic fire_en;
    logic locked;
    logic overspeed;
  } ign_out_t;

  typedef enum logic [1:0] {IGN_OFF, IGN_ON, IGN_LOCK} ign_st_t;

  // Reset values
  localparam in_cfg_t  IN_CFG_RST = '{cam: 1'b0, mode: PU_PASSIVE,
                                      events: 9'h000, disc: DISC_UNUSED};
  localparam spd_cfg_t SPD_RST    = '{rel: 16'h0000, sec: 16'h0000,
                                      nom: 16'h0000, ovs: 16'h0000};
  localparam logic [7:0] LOAD_RST = 8'h00;

endpackage : pickup_pkg

//--- test/pickup_sensor_model.sv
// Pickup sensor model: tooth events on the speed and index pickup lines.
// Assumes teeth and pattern change only while en is low; a shorter period
// set in a run ends the slot in progress early.
`timescale 1ns/1ps
module pickup_sensor_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic [31:0] period,
  input  wire logic [8:0]  teeth,
  input  wire logic [1:0]  pat,
  input  wire logic [1:0]  idle_hi,
  output logic      [1:0]  level
);
  logic [31:0] cyc_q;
  logic [8:0]  slot_q;
  logic [31:0] qtr;
  logic        tooth0;
  logic        tooth1;
  //////////////////////////////////////////////////////////////////////////
  // Slot counter stands still outside a run, so the lines rest at idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q  <= '0;
      slot_q <= '0;
    end else if (!en || cyc_q >= period - 32'h1) begin
      cyc_q  <= '0;
      slot_q <= (!en || slot_q >= teeth - 9'h1) ? 9'h000 : slot_q + 9'h1;
    end else begin
      cyc_q  <= cyc_q + 32'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Pattern 0 even, 1 last tooth missing, 2 extra tooth mid slot 0
  always_comb begin
    qtr    = period >> 2;
    tooth0 = en && ((cyc_q < qtr && !(pat == 2'h1 &&
              slot_q == teeth - 9'h1)) || (pat == 2'h2 &&
              slot_q == 9'h000 && cyc_q >= 2 * qtr && cyc_q < 3 * qtr));
    tooth1 = en && slot_q == 9'h000 && cyc_q < qtr;
    level  = {tooth1, tooth0} ^ idle_hi;
  end
endmodule : pickup_sensor_model

//--- test/pickup_decode_speed_guard_tb.sv
// Testbench: APB configuration, speed guard and index decoding.
// Assumes a 10 MHz pclk and a shortened standstill count.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  err_total++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
  $time, got, exp); end end
module pickup_decode_speed_guard_tb;
  import pickup_pkg::*;
  localparam int unsigned STOP = 8000; // Above the longest tooth period
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pu_level;
  ign_out_t    ign;
  logic [1:0]  index_pulse;
  logic        en = 0;
  logic [31:0] period = 32'h64;
  logic [8:0]  teeth = 9'h003;
  logic [1:0]  pat = 0;
  logic [1:0]  idle_hi = 0;
  logic        cnt_on = 0;
  logic [15:0] idx0;
  logic [15:0] idx1;
  logic [31:0] rd;
  logic        se;
  int          err_total = 0;
  int          checks = 0;
  //////////////////////////////////////////////////////////////////////////
  always #50 pclk = ~pclk;
  pickup_decode_speed_guard #(.STOP_CYCLES(STOP)) pickup_decode_speed_guard_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pu_level(pu_level), .ign(ign),
    .index_pulse(index_pulse));
  pickup_sensor_model pickup_sensor_model_i (
    .clk(pclk), .rst_n(presetn), .en(en), .period(period), .teeth(teeth),
    .pat(pat), .idle_hi(idle_hi), .level(pu_level));
  // Index pulses counted only inside a window clear of edge effects
  always @(posedge pclk) begin
    if (cnt_on) begin
      idx0 += 16'(index_pulse[0]);
      idx1 += 16'(index_pulse[1]);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // One APB transfer; waits for pready without assuming a latency
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK(pready, 1'b1)
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  function automatic in_cfg_t mk(disc_t d, logic [8:0] n, pu_mode_t m,
                                 logic c);
    return '{cam: c, mode: m, events: n, disc: d};
  endfunction : mk
  function automatic in_cfg_t evn(logic [8:0] n);
    return mk(DISC_EVEN, n, PU_PASSIVE, 0);
  endfunction : evn
  // Shadow writes, commit, then error field and acceptance
  task automatic cfg(input in_cfg_t c0, input in_cfg_t c1,
                     input logic [15:0] rl, sc, nm, ov, input logic [3:0] e);
    apb(1, OFF_IN0, 32'(c0));
    apb(1, OFF_IN1, 32'(c1));
    apb(1, OFF_REL, {16'h0000, rl});
    apb(1, OFF_SEC, {16'h0000, sc});
    apb(1, OFF_NOM, {16'h0000, nm});
    apb(1, OFF_OVS, {16'h0000, ov});
    apb(1, OFF_CTRL, 32'h2);
    apb(0, OFF_STATUS, 32'h0);
    `CHK(rd[4:1], e)
    if (e == 4'h0) `CHK(rd[7], 1'b1)
  endtask : cfg
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(0, OFF_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0100)
    `CHK(ign, 3'h0)
    apb(1, OFF_RPM, 32'h0000_FFFF);
    apb(0, OFF_RPM, 32'h0);
    `CHK(rd, 32'h0000_0000)
    apb(0, 8'h40, 32'h0);
    `CHK(se, 1'b1)
  endtask : t_reset
  // Refusals at each limit, then acceptance exactly at the limits
  task automatic t_refuse();
    in_cfg_t u;
    u = mk(DISC_UNUSED, 9'h000, PU_PASSIVE, 0);
    cfg(evn(9'h002), u, 100, 400, 900, 960, 1);
    cfg(evn(9'h1F5), u, 10, 40, 90, 100, 1);
    cfg(evn(9'h1F4), u, 100, 400, 900, 961, 2);
    cfg(evn(9'h003), u, 129, 400, 900, 960, 4);
    cfg(evn(9'h003), u, 100, 451, 900, 960, 4);
    cfg(evn(9'h003), u, 100, 400, 900, 6001, 8);
    cfg(evn(9'h1F4), u, 128, 450, 900, 960, 0);
    apb(1, OFF_LOAD, 32'h20);
    apb(1, OFF_CTRL, 32'h2);
    apb(0, OFF_STATUS, 32'h0);
    `CHK(rd[4:1] != 4'h0, 1'b1)
    apb(1, OFF_LOAD, 32'h1F);
    apb(1, OFF_CTRL, 32'h2);
    apb(0, OFF_STATUS, 32'h0);
    `CHK(rd[4:1], 4'h0)
  endtask : t_refuse
  // Pickups go quiet: lockout ends at standstill, stopped flag shows
  task automatic stop_check();
    en <= 0;
    cyc(STOP + 2000);
    `CHK(ign, 3'h0)
    apb(0, OFF_STATUS, 32'h0);
    `CHK(rd[8], 1'b1)
  endtask : stop_check
  // Even 500 tooth crank disc: rpm = 1200000 / period
  task automatic t_guard();
    apb(1, OFF_CTRL, 32'h1);
    cyc(3);
    `CHK(ign.fire_en, 1'b0)
    period <= 32'd6000;
    teeth <= 9'h1F4;
    pat <= 0;
    idle_hi <= 0;
    en <= 1;
    cyc(14000);
    apb(0, OFF_RPM, 32'h0);
    `CHK(rd, 32'h0000_00C8)
    `CHK(ign.fire_en, 1'b1)
    apb(1, OFF_CTRL, 32'h0);
    cyc(3);
    `CHK(ign.fire_en, 1'b0)
    apb(1, OFF_CTRL, 32'h1);
    cyc(3);
    `CHK(ign.fire_en, 1'b1)
    period <= 32'd2000;
    cyc(8000);
    apb(0, OFF_RPM, 32'h0);
    `CHK(rd, 32'h0000_0258)
    period <= 32'd1000;
    cyc(5000);
    `CHK(ign, 3'b011)
    stop_check();
    period <= 32'd2000;
    en <= 1;
    cyc(6000);
    `CHK(ign.fire_en, 1'b1)
    apb(1, OFF_CTRL, 32'h0);
    apb(1, OFF_CTRL, 32'h1);
    cyc(3);
    `CHK(ign, 3'b010)
    stop_check();
  endtask : t_guard
  // Three tooth disc per pattern; single cam event on the index input
  task automatic t_index();
    disc_t       d[3] = '{DISC_EVEN, DISC_MISSING, DISC_EXTRA};
    logic [15:0] x[3] = '{16'h0000, 16'h0003, 16'h0003};
    for (int p = 0; p < 3; p++) begin
      cfg(mk(d[p], 9'h003, PU_IDLE_LOW, 0), mk(DISC_SINGLE, 9'h001,
          PU_IDLE_HIGH, 1), 128, 450, 900, 960, 0);
      period <= 32'd200;
      pat <= 2'(p);
      teeth <= 9'h003;
      idle_hi <= 2'b10;
      en <= 1;
      cyc(2100);
      idx0 = 0;
      idx1 = 0;
      cnt_on <= 1;
      cyc(1800);
      cnt_on <= 0;
      en <= 0;
      `CHK(idx0, x[p])
      `CHK(idx1, 16'h0003)
    end
  endtask : t_index
  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_refuse();
    t_guard();
    t_index();
    tally_and_finish();
  end
  // Watchdog well beyond the expected run of about 65000 cycles
  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end
endmodule : pickup_decode_speed_guard_tb
